// ===== pkg/exfr_pkg.sv
`default_nettype none
package exfr_pkg;
  // ------------------------------------------------------------
  // Error code layout
  // ------------------------------------------------------------
  localparam int EC_W        = 32;  // Pushed error code width
  localparam int EC_EXT_BIT  = 0;   // External event flag
  localparam int EC_TBL_BIT  = 1;   // Gate table flag
  localparam int EC_LOC_BIT  = 2;   // Local table select flag
  localparam int EC_IDX_LSB  = 3;   // Selector index field
  localparam int EC_IDX_W    = 13;  // Selector index width
  localparam int EC_LOW_W    = 16;  // Lower word, upper half reserved
  // ------------------------------------------------------------
  // Gate descriptor layout
  // ------------------------------------------------------------
  localparam int GATE_SHIFT_LONG = 4;   // 16-byte gates
  localparam int GATE_SHIFT_LEG  = 3;   // 8-byte gates
  localparam int GATE_TYPE_LSB   = 40;  // Bits 11:8 of bytes 7:4
  localparam int GATE_TYPE_W     = 4;
  localparam int ALT_IDX_LSB     = 32;  // Bits 4:0 of bytes 7:4
  localparam int ALT_IDX_W       = 5;
  localparam int OFS_MID_LSB     = 48;  // Offset bits 31:16
  localparam int OFS_PART_W      = 16;
  localparam logic [3:0] TYPE_INT64  = 4'hE;
  localparam logic [3:0] TYPE_TRAP64 = 4'hF;
  localparam logic [3:0] TYPE_INT16  = 4'h6;
  localparam logic [3:0] TYPE_TRAP16 = 4'h7;
  // ------------------------------------------------------------
  // Stack frame
  // ------------------------------------------------------------
  localparam logic [63:0] ALIGN_MASK  = 64'hFFFF_FFFF_FFFF_FFF0;
  localparam logic [3:0]  BYTES_WORD  = 4'h2;
  localparam logic [3:0]  BYTES_DWORD = 4'h4;
  localparam logic [3:0]  BYTES_QWORD = 4'h8;
  localparam logic [1:0]  PL_USER     = 2'h3;
  localparam logic [2:0]  POPS_SHORT  = 3'h3;  // Pointer, code, flags
  localparam logic [2:0]  POPS_FULL   = 3'h5;  // Plus stack sel/ptr
  // Selector reference source
  typedef enum logic [1:0] {
    SRC_NONE       = 2'b00,
    SRC_GLOBAL     = 2'b01,
    SRC_LOCAL      = 2'b10,
    SRC_GATE_TABLE = 2'b11
  } exfr_src_e;
  // Frame items in push order
  typedef enum logic [2:0] {
    ITEM_SS    = 3'b000,
    ITEM_SP    = 3'b001,
    ITEM_FLAGS = 3'b010,
    ITEM_CODE  = 3'b011,
    ITEM_IP    = 3'b100,
    ITEM_ERR   = 3'b101
  } exfr_item_e;
  // Delivery sequencer
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_PUSH  = 2'b10
  } exfr_state_e;
endpackage
`default_nettype wire

// ===== pkg/exfr_core_if.sv
`default_nettype none
interface exfr_core_if;
  // Gate descriptor and target segment
  logic [63:0]               gateLo;
  logic [31:0]               gateHi;
  logic                      csLong;
  logic                      csDefault;
  logic [3:0]                gateType;
  logic [4:0]                altStackIdx;
  logic [63:0]               targetIp;
  logic                      gateOk;
  logic                      protZero;
  logic                      protVector;
  // Error code request and result
  logic                      extEvent;
  exfr_pkg::exfr_src_e       src;
  logic [12:0]               selIndex;
  logic                      nullRef;
  logic [31:0]               errorCode;
  // Gate checker side
  modport gate (input gateLo, gateHi, csLong, csDefault,
                output gateType, altStackIdx, targetIp, gateOk,
                protZero, protVector);
  // Error code builder side
  modport code (input extEvent, src, selIndex, nullRef,
                output errorCode);
  // Sequencer side
  modport owner (output gateLo, gateHi, csLong, csDefault, extEvent,
                 src, selIndex, nullRef,
                 input gateType, altStackIdx, targetIp, gateOk,
                 protZero, protVector, errorCode);
endinterface
`default_nettype wire

// ===== rtl/exfr_error_code.sv
`default_nettype none
module exfr_error_code (
  // Request and result
  exfr_core_if.code c
);
  // ------------------------------------------------------------
  // Flag and index assembly
  // ------------------------------------------------------------
  wire        tableRef = (c.src == exfr_pkg::SRC_GATE_TABLE);
  wire        localRef = (c.src == exfr_pkg::SRC_LOCAL) & ~tableRef;
  wire        isNull   = c.nullRef | (c.src == exfr_pkg::SRC_NONE);
  wire [31:0] raw;
  // Upper half held reserved
  assign raw[exfr_pkg::EC_W-1:exfr_pkg::EC_LOW_W] = '0;
  assign raw[exfr_pkg::EC_IDX_LSB +: exfr_pkg::EC_IDX_W] =
         c.selIndex;
  assign raw[exfr_pkg::EC_LOC_BIT] = localRef;
  assign raw[exfr_pkg::EC_TBL_BIT] = tableRef;
  assign raw[exfr_pkg::EC_EXT_BIT] = c.extEvent;
  // Null reference gives an all-zero code
  assign c.errorCode = isNull ? '0 : raw;
endmodule
`default_nettype wire

// ===== rtl/exfr_gate_check.sv
`default_nettype none
module exfr_gate_check #(
  parameter int VA_W = 48  // Implemented linear address width
) (
  // Descriptor in, verdict out
  exfr_core_if.gate g
);
  if (VA_W < 33 || VA_W > 63) begin : g_badWidth
    $error("exfr_gate_check: VA_W out of range");
  end
  // ------------------------------------------------------------
  // Field extraction
  // ------------------------------------------------------------
  assign g.gateType =
         g.gateLo[exfr_pkg::GATE_TYPE_LSB +: exfr_pkg::GATE_TYPE_W];
  assign g.altStackIdx =
         g.gateLo[exfr_pkg::ALT_IDX_LSB +: exfr_pkg::ALT_IDX_W];
  assign g.targetIp = {g.gateHi,
         g.gateLo[exfr_pkg::OFS_MID_LSB +: exfr_pkg::OFS_PART_W],
         g.gateLo[0 +: exfr_pkg::OFS_PART_W]};
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  wire [64-VA_W:0] hiBits    = g.targetIp[63:VA_W-1];
  wire             canonical = (&hiBits) | ~(|hiBits);
  wire             typeLong  = (g.gateType == exfr_pkg::TYPE_INT64) |
                               (g.gateType == exfr_pkg::TYPE_TRAP64);
  wire             type16    = (g.gateType == exfr_pkg::TYPE_INT16) |
                               (g.gateType == exfr_pkg::TYPE_TRAP16);
  wire             csIs64    = g.csLong & ~g.csDefault;
  // Bad type, 16-bit gate or non-canonical target fault with zero
  assign g.protZero   = ~typeLong | type16 | ~canonical;
  // Wrong target segment faults with the vector number
  assign g.protVector = ~g.protZero & ~csIs64;
  assign g.gateOk     = ~g.protZero & ~g.protVector;
endmodule
`default_nettype wire

// ===== rtl/exfr_unit.sv
`default_nettype none
module exfr_unit #(
  parameter int VA_W = 48  // Linear address width for canonical check
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // Delivery request
  input  wire logic                deliverReq,
  input  wire logic [7:0]          vector,
  input  wire logic                extEvent,
  input  wire logic                softIntInstr,
  input  wire logic                pinInterrupt,
  input  wire logic                vectorHasCode,
  input  wire exfr_pkg::exfr_src_e faultSrc,
  input  wire logic [12:0]         faultIndex,
  input  wire logic                nullRef,
  input  wire logic                longModeActive,
  input  wire logic                gate32,
  input  wire logic [1:0]          currentPrivilegeLevel,
  input  wire logic [1:0]          newPrivilegeLevel,
  // Gate descriptor and target segment
  input  wire logic [63:0]         gateLo,
  input  wire logic [31:0]         gateHi,
  input  wire logic                csLong,
  input  wire logic                csDefault,
  // Interrupted context
  input  wire logic [63:0]         innerSp,
  input  wire logic [15:0]         oldSs,
  input  wire logic [63:0]         oldSp,
  input  wire logic [63:0]         oldFlags,
  input  wire logic [15:0]         oldCs,
  input  wire logic [63:0]         oldIp,
  // Stack write port
  output logic                     wrValid,
  input  wire logic                wrReady,
  output logic [63:0]              wrAddr,
  output logic [63:0]              wrData,
  output logic [3:0]               wrBytes,
  // Delivery result
  output logic                     busy,
  output logic [11:0]              gateOffset,
  output logic                     deliverDone,
  output logic [63:0]              handlerIp,
  output logic [4:0]               altStackIdx,
  output logic [15:0]              newSs,
  output logic [63:0]              newSp,
  output logic                     protFault,
  output logic [31:0]              protErrorCode,
  // Return request
  input  wire logic                retReq,
  input  wire logic                retMode64,
  input  wire logic                retCplChange,
  input  wire logic                retTargetMode64,
  input  wire logic [1:0]          retTargetPl,
  input  wire logic [15:0]         retPoppedSs,
  // Return result
  output logic                     retDone,
  output logic                     retPopStack,
  output logic                     retLoadSsDesc,
  output logic                     retFault,
  output logic [2:0]               retPopCount
);
  // ------------------------------------------------------------
  // Latched request
  // ------------------------------------------------------------
  exfr_pkg::exfr_state_e state;      // Sequencer state
  exfr_pkg::exfr_item_e  item;       // Frame item in flight
  exfr_pkg::exfr_src_e   srcQ;       // Referenced table
  logic [7:0]            vecQ;       // Vector number
  logic                  extQ;       // External cause
  logic                  codeQ;      // Error code to be pushed
  logic                  nullQ;      // Null reference
  logic                  lmaQ;       // Long mode active
  logic                  wideQ;      // 32-bit legacy gate
  logic                  plChgQ;     // Privilege change
  logic [1:0]            newPlQ;     // Handler privilege
  logic [12:0]           idxQ;       // Selector index
  logic [63:0]           top;        // Current frame top
  logic [31:0]           errQ;       // Error code captured

  exfr_core_if core ();

  // Error code builder
  exfr_error_code u_code (
    .c (core.code)
  );

  // Gate decode and checks
  exfr_gate_check #(.VA_W(VA_W)) u_gate (
    .g (core.gate)
  );

  // ------------------------------------------------------------
  // Checker inputs
  // ------------------------------------------------------------
  assign core.gateLo    = gateLo;
  assign core.gateHi    = gateHi;
  assign core.csLong    = csLong;
  assign core.csDefault = csDefault;
  // Gate checks only apply with long mode active
  wire chkZero = lmaQ & core.protZero;
  wire chkVec  = lmaQ & core.protVector;
  // Segment fault reports the vector as a gate table index
  assign core.extEvent = extQ;
  assign core.src      = chkVec ? exfr_pkg::SRC_GATE_TABLE : srcQ;
  assign core.selIndex = chkVec ? {5'h00, vecQ} : idxQ;
  assign core.nullRef  = chkZero | (nullQ & ~chkVec);

  // ------------------------------------------------------------
  // Frame item selection
  // ------------------------------------------------------------
  // Stack pair pushed always in long mode, else on change
  wire stackPair = lmaQ | plChgQ;
  // Item width per mode and gate size
  wire [3:0] itemBytes = lmaQ  ? exfr_pkg::BYTES_QWORD :
                         wideQ ? exfr_pkg::BYTES_DWORD :
                                 exfr_pkg::BYTES_WORD;

  // Whether an item belongs in this frame
  function automatic logic itemNeeded(
    input exfr_pkg::exfr_item_e it,
    input logic                 pair,
    input logic                 code
  );
    unique case (it)
      exfr_pkg::ITEM_SS, exfr_pkg::ITEM_SP: itemNeeded = pair;
      exfr_pkg::ITEM_ERR: itemNeeded = code;
      default: itemNeeded = 1'b1;
    endcase
  endfunction

  wire need    = itemNeeded(item, stackPair, codeQ);
  wire inPush  = (state == exfr_pkg::ST_PUSH);
  wire advance = inPush & (~need | wrReady);
  wire lastIt  = (item == exfr_pkg::ITEM_ERR);
  wire [63:0] nextTop = need ? top - {60'h0, itemBytes} : top;

  // Item value, zero-extended to 64 bits
  always_comb begin
    unique case (item)
      exfr_pkg::ITEM_SS:    wrData = {48'h0, oldSs};
      exfr_pkg::ITEM_SP:    wrData = oldSp;
      exfr_pkg::ITEM_FLAGS: wrData = oldFlags;
      exfr_pkg::ITEM_CODE:  wrData = {48'h0, oldCs};
      exfr_pkg::ITEM_IP:    wrData = oldIp;
      default:              wrData = {32'h0, errQ};
    endcase
  end

  assign wrValid = inPush & need;
  assign wrAddr  = top - {60'h0, itemBytes};
  assign wrBytes = itemBytes;
  assign busy    = (state != exfr_pkg::ST_IDLE);

  // ------------------------------------------------------------
  // Frame base selection
  // ------------------------------------------------------------
  // Old pointer is pushed from the oldSp input, not frameSp, so alignment is safe
  wire [63:0] baseSp  = plChgQ ? innerSp : oldSp;
  wire [63:0] frameSp = lmaQ ? (baseSp & exfr_pkg::ALIGN_MASK)
                             : baseSp;
  // Error code suppressed for pin and software sources
  wire takeCode = vectorHasCode & ~pinInterrupt & ~softIntInstr;

  // ------------------------------------------------------------
  // Request capture
  // ------------------------------------------------------------
  // Latch the event on acceptance in idle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vecQ   <= 8'h00;
      extQ   <= 1'b0;
      codeQ  <= 1'b0;
      nullQ  <= 1'b0;
      srcQ   <= exfr_pkg::SRC_NONE;
      idxQ   <= 13'h0000;
      lmaQ   <= 1'b0;
      wideQ  <= 1'b0;
      plChgQ <= 1'b0;
      newPlQ <= 2'h0;
    end else if (deliverReq && state == exfr_pkg::ST_IDLE) begin
      vecQ   <= vector;
      extQ   <= extEvent;
      codeQ  <= takeCode;
      nullQ  <= nullRef;
      srcQ   <= faultSrc;
      idxQ   <= faultIndex;
      lmaQ   <= longModeActive;
      wideQ  <= gate32;
      plChgQ <= (newPrivilegeLevel != currentPrivilegeLevel);
      newPlQ <= newPrivilegeLevel;
    end
  end

  // Gate table byte offset
  assign gateOffset = lmaQ ? {vecQ, 4'h0}
                           : {1'b0, vecQ, 3'h0};

  // ------------------------------------------------------------
  // Delivery sequencer
  // ------------------------------------------------------------
  // Check the gate, then push items newest last
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state       <= exfr_pkg::ST_IDLE;
      item        <= exfr_pkg::ITEM_SS;
      top         <= 64'h0;
      errQ        <= 32'h0;
      deliverDone <= 1'b0;
      protFault   <= 1'b0;
    end else begin
      deliverDone <= 1'b0;
      protFault   <= 1'b0;
      unique case (state)
        exfr_pkg::ST_IDLE: begin
          if (deliverReq) begin
            state <= exfr_pkg::ST_CHECK;
          end
        end
        exfr_pkg::ST_CHECK: begin
          errQ <= core.errorCode;
          item <= exfr_pkg::ITEM_SS;
          top  <= frameSp;
          if (chkZero || chkVec) begin
            // Faulting gate, nothing pushed
            protFault <= 1'b1;
            state     <= exfr_pkg::ST_IDLE;
          end else begin
            state <= exfr_pkg::ST_PUSH;
          end
        end
        exfr_pkg::ST_PUSH: begin
          if (advance) begin
            top <= nextTop;
            if (lastIt) begin
              deliverDone <= 1'b1;
              state       <= exfr_pkg::ST_IDLE;
            end else begin
              item <= exfr_pkg::exfr_item_e'(item + 3'h1);
            end
          end
        end
        default: state <= exfr_pkg::ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Delivery results
  // ------------------------------------------------------------
  // Handler context captured in the check cycle, new stack pointer at completion
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      handlerIp     <= 64'h0;
      altStackIdx   <= 5'h00;
      newSs         <= 16'h0000;
      newSp         <= 64'h0;
      protErrorCode <= 32'h0;
    end else if (state == exfr_pkg::ST_CHECK) begin
      handlerIp     <= core.targetIp;
      altStackIdx   <= core.altStackIdx;
      protErrorCode <= core.errorCode;
      // Null selector carrying the new privilege as its RPL on a privilege change, else oldSs
      newSs <= plChgQ ? {14'h0000, newPlQ} : oldSs;
    end else if (advance && lastIt) begin
      newSp <= nextTop;
    end
  end

  // ------------------------------------------------------------
  // Interrupt return
  // ------------------------------------------------------------
  wire retPop  = retMode64 | retCplChange;
  wire ssNull  = (retPoppedSs[15:2] == 14'h0000);
  wire nullOk  = retTargetMode64 & (retTargetPl != exfr_pkg::PL_USER);

  // One-cycle verdict on the popped frame
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      retDone       <= 1'b0;
      retPopStack   <= 1'b0;
      retLoadSsDesc <= 1'b0;
      retFault      <= 1'b0;
      retPopCount   <= 3'h0;
    end else begin
      retDone       <= retReq;
      retPopStack   <= retReq & retPop;
      retLoadSsDesc <= retReq & retPop & ~ssNull;
      retFault      <= retReq & retPop & ssNull & ~nullOk;
      // Frame pops exclude any error code
      retPopCount   <= ~retReq ? 3'h0 :
                       retPop  ? exfr_pkg::POPS_FULL
                               : exfr_pkg::POPS_SHORT;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  ec_upper_a: assert property (core.errorCode[31:16] == 16'h0000)
    else $error("error code upper half not zero");
  ec_null_a: assert property (core.nullRef |->
      core.errorCode == 32'h0)
    else $error("null reference gave nonzero code");
  ec_flags_a: assert property (core.errorCode[1] |->
      !core.errorCode[2])
    else $error("local flag set with table flag");
  no_pin_code_a: assert property (deliverReq && pinInterrupt &&
      state == exfr_pkg::ST_IDLE |=> !codeQ)
    else $error("error code kept for pin interrupt");
  frame_align_a: assert property (state == exfr_pkg::ST_CHECK && lmaQ
      && !chkZero && !chkVec |=> top[3:0] == 4'h0)
    else $error("long mode frame not aligned");
  qword_push_a: assert property (wrValid && lmaQ |->
      wrBytes == exfr_pkg::BYTES_QWORD)
    else $error("long mode push not 8 bytes");
  push_down_a: assert property (wrValid && wrReady |=>
      top == $past(top) - {60'h0, $past(wrBytes)})
    else $error("frame top did not step down");
  gate_off_a: assert property (lmaQ |->
      gateOffset == {vecQ, 4'h0})
    else $error("gate offset not vector times 16");
  cs_check_a: assert property (state == exfr_pkg::ST_CHECK && lmaQ &&
      !core.protZero && (!csLong || csDefault) |=>
      protFault && protErrorCode[10:3] == vecQ)
    else $error("bad target segment not faulted");
  ss_null_a: assert property (retReq && retMode64 &&
      retPoppedSs[15:2] == 14'h0000 && !retTargetMode64 |=>
      retFault && !retLoadSsDesc)
    else $error("null selector return not refused");
endmodule
`default_nettype wire

// ===== tb/exfr_stack_model.sv
`default_nettype none
module exfr_stack_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Stack write port
  input  wire logic        wrValid,
  output logic             wrReady,
  input  wire logic [63:0] wrAddr,
  input  wire logic [63:0] wrData,
  input  wire logic [3:0]  wrBytes,
  // Pacing and record of one frame
  input  wire logic        slow,
  input  wire logic        clr,
  output int               n,
  output logic [63:0]      firstAddr,
  output logic [63:0]      lastData,
  output logic [3:0]       lastBytes
);
  timeunit 1ns;
  timeprecision 1ns;
  // Memory side: stalls every other cycle when slow, logs accepted items
  always @(posedge clock) begin
    if (!rst_n || clr) begin
      n <= 0;
    end else if (wrValid && wrReady) begin
      if (n == 0) begin
        firstAddr <= wrAddr;
      end
      lastData  <= wrData;
      lastBytes <= wrBytes;
      n         <= n + 1;
    end
    wrReady <= !rst_n ? 1'b0 : (slow ? !wrReady : 1'b1);
  end
endmodule
`default_nettype wire

// ===== tb/exfr_unit_tb.sv
`default_nettype none
module exfr_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Error code cases and return cases
  typedef struct packed {
    logic e; exfr_pkg::exfr_src_e s; logic [12:0] x; logic n; logic [31:0] c;
  } exfr_row_s;
  typedef struct packed {
    logic m; logic c; logic t; logic [1:0] p; logic [15:0] ss; logic f;
    logic [3:0] x;
  } exfr_ret_s;
  localparam logic [63:0] GOOD_GATE = 64'h1234_8E03_0000_5678;
  // Design inputs
  logic        clock, rst_n, deliverReq, extEvent, softIntInstr, pinInterrupt;
  logic        vectorHasCode, nullRef, longModeActive, gate32, csLong;
  logic        csDefault, wrReady, retReq, retMode64, retCplChange;
  logic        retTargetMode64, slow, clr, pf;
  logic [7:0]  vector;
  logic [12:0] faultIndex;
  logic [1:0]  currentPrivilegeLevel, newPrivilegeLevel, retTargetPl;
  logic [63:0] gateLo, innerSp, oldSp, oldFlags, oldIp;
  logic [31:0] gateHi;
  logic [15:0] oldSs, oldCs, retPoppedSs;
  exfr_pkg::exfr_src_e faultSrc;
  // Design outputs and model record
  logic        wrValid, busy, deliverDone, protFault, retDone, retPopStack;
  logic        retLoadSsDesc, retFault;
  logic [63:0] wrAddr, wrData, handlerIp, newSp, firstAddr, lastData;
  logic [3:0]  wrBytes, lastBytes;
  logic [11:0] gateOffset;
  logic [4:0]  altStackIdx;
  logic [15:0] newSs;
  logic [31:0] protErrorCode;
  logic [2:0]  retPopCount;
  int          n, fails, checks, k;
  exfr_row_s rows [5] = '{
    {1'b1, exfr_pkg::SRC_GLOBAL, 13'h0005, 1'b0, 32'h0000_0029},
    {1'b0, exfr_pkg::SRC_LOCAL, 13'h1FFF, 1'b0, 32'h0000_FFFC},
    {1'b0, exfr_pkg::SRC_GATE_TABLE, 13'h0021, 1'b0, 32'h0000_010A},
    {1'b1, exfr_pkg::SRC_NONE, 13'h0007, 1'b0, 32'h0000_0000},
    {1'b0, exfr_pkg::SRC_LOCAL, 13'h0003, 1'b1, 32'h0000_0000}};
  exfr_ret_s rets [6] = '{
    {3'b101, 2'h0, 16'h0010, 1'b0, 4'hD}, {3'b000, 2'h3, 16'h002B, 1'b0, 4'h3},
    {3'b010, 2'h3, 16'h002B, 1'b0, 4'hD}, {3'b111, 2'h0, 16'h0000, 1'b0, 4'hD},
    {3'b111, 2'h3, 16'h0003, 1'b1, 4'h0}, {3'b110, 2'h0, 16'h0000, 1'b1, 4'h0}};
  // Design and far side
  exfr_unit exfr_unit_i (.*);
  exfr_stack_model exfr_stack_model_i (.clock, .rst_n, .wrValid, .wrReady,
    .wrAddr, .wrData, .wrBytes, .slow, .clr, .n, .firstAddr, .lastData,
    .lastBytes);
  always #50 clock = ~clock;
  // Compare and count
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One delivery, waits boundedly for done or fault
  task automatic deliver();
    deliverReq <= 1'b1;
    clr        <= 1'b1;
    @(posedge clock);
    deliverReq <= 1'b0;
    clr        <= 1'b0;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (deliverDone !== 1'b1 && protFault !== 1'b1 && k < 40);
    pf = protFault;
  endtask
  // Watchdog
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    test_done();
  end
  // Main sequence
  initial begin
    {clock, rst_n, deliverReq, extEvent, softIntInstr, pinInterrupt} = '0;
    {nullRef, gate32, csDefault, retReq, retMode64, retCplChange} = '0;
    {retTargetMode64, slow, clr} = '0;
    {vectorHasCode, longModeActive, csLong} = '1;
    {vector, faultIndex, currentPrivilegeLevel, newPrivilegeLevel} = '0;
    {retTargetPl, gateHi, retPoppedSs, oldFlags, oldIp, oldSs, oldCs} = '0;
    {gateLo, innerSp, oldSp} = {GOOD_GATE, 64'h2_0005, 64'h8F37};
    faultSrc = exfr_pkg::SRC_NONE;
    repeat (4) @(posedge clock);
    #1;
    chk("busy", busy, 0);
    chk("wrValid", wrValid, 0);
    chk("gateOffset", gateOffset, 0);
    @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      extEvent   <= rows[i].e;
      faultSrc   <= rows[i].s;
      faultIndex <= rows[i].x;
      nullRef    <= rows[i].n;
      vector     <= 8'h20 + 8'(i);
      slow       <= i[0];
      deliver();
      chk("errorCode", lastData, {32'h0, rows[i].c});
      chk("itemCount", n, 6);
      chk("frameTop", firstAddr, 64'h8F28);
      chk("newSp", newSp, 64'h8F00);
      chk("itemBytes", lastBytes, 8);
      chk("gateOffset", gateOffset, {vector, 4'h0});
    end
    chk("handlerIp", handlerIp, 64'h1234_5678);
    chk("altStackIdx", altStackIdx, 5'h03);
    for (int j = 0; j < 2; j++) begin
      @(posedge clock);
      pinInterrupt <= (j == 0);
      softIntInstr <= (j == 1);
      deliver();
      chk("itemCount", n, 5);
    end
    // Legacy gates, narrow pushes, no stack pair
    for (int g = 0; g < 2; g++) begin
      @(posedge clock);
      {pinInterrupt, softIntInstr, longModeActive} <= '0;
      gate32 <= g[0];
      deliver();
      chk("itemCount", n, 4);
      chk("itemBytes", lastBytes, g ? 4 : 2);
      chk("gateOffset", gateOffset, {1'b0, vector, 3'h0});
    end
    @(posedge clock);
    longModeActive <= 1'b1;
    {currentPrivilegeLevel, newPrivilegeLevel} <= 4'hD;
    deliver();
    chk("newSs", newSs, 16'h0001);
    chk("frameTop", firstAddr, 64'h1_FFF8);
    // Bad gate type, non-canonical target, bad code segment, trap gate
    for (int f = 0; f < 4; f++) begin
      @(posedge clock);
      gateLo    <= {GOOD_GATE[63:44], f == 0 ? 4'h6 : f == 3 ? 4'hF : 4'hE,
                    GOOD_GATE[39:0]};
      gateHi    <= (f == 1) ? 32'h0001_0000 : 32'h0;
      csDefault <= (f == 2);
      {extEvent, vector} <= 9'h10D;
      deliver();
      chk("protFault", pf, f != 3);
      if (f != 3) chk("protCode", protErrorCode, f == 2 ? 32'h6B : 0);
    end
    for (int r = 0; r < 6; r++) begin
      @(posedge clock);
      {retMode64, retCplChange, retTargetMode64} <= {rets[r].m, rets[r].c,
                                                     rets[r].t};
      retTargetPl <= rets[r].p;
      retPoppedSs <= rets[r].ss;
      retReq      <= 1'b1;
      @(posedge clock);
      retReq <= 1'b0;
      // Verdict stands for the cycle after the request edge
      #1;
      chk("retFault", retFault, rets[r].f);
      if (!rets[r].f)
        chk("retPop", {retDone, retPopStack, retPopCount},
            {1'b1, rets[r].x});
      if (r == 3) chk("retLoadSsDesc", retLoadSsDesc, 0);
    end
    test_done();
  end
endmodule
`default_nettype wire
